//--- src/cgosd_top.v
`timescale 1ns/1ns
`include "cgosd_regs.vh"

module cgosd_top #(
    parameter OSC_TIMEOUT = `CGOSD_OSC_TIMEOUT_CYC
) (
    input  wire       clk_sys,        // System clock 50 MHz
    input  wire       sys_rst,        // Async reset, active high
    input  wire [7:0] reg_addr,       // Register byte address
    input  wire [7:0] reg_wdata,      // Write data
    input  wire       reg_wr,         // Write strobe
    input  wire       reg_rd,         // Read strobe
    output reg  [7:0] reg_rdata,      // Read data, cycle after strobe
    input  wire       main_osc_in,    // Main oscillator, async
    output reg        osd_irq,        // Detection interrupt pulse (watchdog vector)
    output reg        osd_rst_req,    // Oscillation-stop reset, held
    output reg        ring_osc_on,    // Ring oscillator run request
    output reg        cpu_on_ring,    // CPU clock from ring oscillator
    output reg        periph_on_ring  // Peripheral clocks from ring oscillator
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] clk_ctrl0_q;
    reg [7:0] clk_ctrl1_q;
    reg [7:0] osd_ctrl_q;
    reg [7:0] pll_ctrl_q;
    reg [7:0] lp_ctrl_q;
    reg [7:0] ring_ctrl_q;
    reg [7:0] pclk_sel_q;
    reg [7:0] pmode0_q;
    reg [7:0] pmode1_q;
    reg [7:0] pwr_ctrl2_q;
    reg [7:0] tb2_q;
    reg [7:0] inv0_q;
    reg [7:0] inv1_q;
    reg [7:0] p9_dir_q;
    reg [7:0] pin_asg_q;
    reg [7:0] ser4_q;
    reg [7:0] nf_dir_q;
    reg [7:0] vdet2_q;
    reg [7:0] vdet_int_q;
    reg [3:0] wprot_q;

    wire osc_running;
    wire stop_evt;
    wire restart_evt;

    wire clk_unlk  = wprot_q[`CGOSD_BIT_CLK_UNLK];
    wire pwr_unlk  = wprot_q[`CGOSD_BIT_PWR_UNLK];
    wire port_unlk = wprot_q[`CGOSD_BIT_PORT_UNLK];
    wire vdet_unlk = wprot_q[`CGOSD_BIT_VDET_UNLK];
    wire lock      = pwr_ctrl2_q[`CGOSD_BIT_CLK_LOCK];

    // Write hit helper
    function wr_hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            wr_hit = (a == ofs);
        end
    endfunction

    // Keep locked bits; mask has 1 where a bit keeps its old value
    function [7:0] merge;
        input [7:0] old;
        input [7:0] nw;
        input [7:0] keep;
        begin
            merge = (old & keep) | (nw & ~keep);
        end
    endfunction

    wire [7:0] ctrl0_keep = lock ? ((8'h01 << `CGOSD_BIT_PCLK_WAIT_OFF) | (8'h01 << `CGOSD_BIT_MAIN_OSC_STOP)
                                  | (8'h01 << `CGOSD_BIT_SYSCLK_SUB)) : 8'h00;
    wire [7:0] ctrl1_keep = lock ? ((8'h01 << `CGOSD_BIT_STOP_REQ) | (8'h01 << `CGOSD_BIT_PLL_SEL))
                                 : 8'h00;
    // Flag and state are hardware status; software may only clear the flag
    wire [7:0] osd_keep   = (8'h01 << `CGOSD_BIT_OSC_STATE) | (lock ? (8'h01 << `CGOSD_BIT_OSD_EN) : 8'h00);

    wire osd_en   = osd_ctrl_q[`CGOSD_BIT_OSD_EN];
    wire osd_act  = osd_ctrl_q[`CGOSD_BIT_OSD_ACT];
    wire osd_flag = osd_ctrl_q[`CGOSD_BIT_OSD_FLAG];
    wire on_sub   = clk_ctrl0_q[`CGOSD_BIT_SYSCLK_SUB];
    wire on_pll   = clk_ctrl1_q[`CGOSD_BIT_PLL_SEL];

    // ----------------------------------------
    // Oscillator watcher
    // ----------------------------------------
    cgosd_stop_det #(
        .TIMEOUT (OSC_TIMEOUT)
    ) u_det (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .osc_in      (main_osc_in),
        .osc_running (osc_running),
        .stop_evt    (stop_evt),
        .restart_evt (restart_evt)
    );

    wire stop_act    = osd_en & stop_evt;
    wire restart_act = osd_en & restart_evt;
    wire int_mode    = osd_act;
    wire irq_fire    = int_mode & (stop_act | restart_act) & ~osd_flag;
    wire wr          = reg_wr;

    // ----------------------------------------
    // Register writes with protection
    // ----------------------------------------
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            clk_ctrl0_q <= `CGOSD_RST_CLK_CTRL0;
            clk_ctrl1_q <= `CGOSD_RST_CLK_CTRL1;
            osd_ctrl_q  <= `CGOSD_RST_OSD_CTRL;
            pll_ctrl_q  <= `CGOSD_RST_PLL_CTRL;
            lp_ctrl_q   <= `CGOSD_RST_GENERIC;
            ring_ctrl_q <= `CGOSD_RST_GENERIC;
            pclk_sel_q  <= `CGOSD_RST_GENERIC;
            pmode0_q    <= `CGOSD_RST_GENERIC;
            pmode1_q    <= `CGOSD_RST_GENERIC;
            pwr_ctrl2_q <= `CGOSD_RST_GENERIC;
            tb2_q       <= `CGOSD_RST_GENERIC;
            inv0_q      <= `CGOSD_RST_GENERIC;
            inv1_q      <= `CGOSD_RST_GENERIC;
            p9_dir_q    <= `CGOSD_RST_GENERIC;
            pin_asg_q   <= `CGOSD_RST_GENERIC;
            ser4_q      <= `CGOSD_RST_GENERIC;
            nf_dir_q    <= `CGOSD_RST_GENERIC;
            vdet2_q     <= `CGOSD_RST_GENERIC;
            vdet_int_q  <= `CGOSD_RST_GENERIC;
            wprot_q     <= 4'h0;
        end else begin
            if (wr && clk_unlk) begin
                if (wr_hit(reg_addr, `CGOSD_OFS_CLK_CTRL0))
                    clk_ctrl0_q <= merge(clk_ctrl0_q, reg_wdata, ctrl0_keep);
                if (wr_hit(reg_addr, `CGOSD_OFS_CLK_CTRL1))
                    clk_ctrl1_q <= merge(clk_ctrl1_q, reg_wdata, ctrl1_keep);
                if (wr_hit(reg_addr, `CGOSD_OFS_PLL_CTRL) && !lock)
                    pll_ctrl_q <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_LP_CTRL))
                    lp_ctrl_q <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_RING_CTRL))
                    ring_ctrl_q <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_PCLK_SEL))
                    pclk_sel_q <= reg_wdata;
            end
            if (wr && pwr_unlk) begin
                if (wr_hit(reg_addr, `CGOSD_OFS_PMODE0))    pmode0_q    <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_PMODE1))    pmode1_q    <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_PWR_CTRL2)) pwr_ctrl2_q <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_TB2_SPEC))  tb2_q       <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_INV_CTRL0)) inv0_q      <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_INV_CTRL1)) inv1_q      <= reg_wdata;
            end
            if (wr && port_unlk) begin
                if (wr_hit(reg_addr, `CGOSD_OFS_P9_DIR))     p9_dir_q  <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_PIN_ASSIGN)) pin_asg_q <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_SER4_CTRL))  ser4_q    <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_NF_DIR))     nf_dir_q  <= reg_wdata;
            end
            if (wr && vdet_unlk) begin
                if (wr_hit(reg_addr, `CGOSD_OFS_VDET_CTRL2)) vdet2_q    <= reg_wdata;
                if (wr_hit(reg_addr, `CGOSD_OFS_VDET_INT))   vdet_int_q <= reg_wdata;
            end

            // Write-protect register; port unlock self-clears on any other write
            if (wr && wr_hit(reg_addr, `CGOSD_OFS_WPROT))
                wprot_q <= reg_wdata[3:0];
            else if (wr)
                wprot_q[`CGOSD_BIT_PORT_UNLK] <= 1'b0;

            // Status bits: software write first, hardware events override so none is lost
            if (wr && clk_unlk && wr_hit(reg_addr, `CGOSD_OFS_OSD_CTRL)) begin
                osd_ctrl_q <= merge(osd_ctrl_q, reg_wdata & ~(8'h01 << `CGOSD_BIT_OSD_FLAG), osd_keep)
                            | (osd_ctrl_q & reg_wdata & (8'h01 << `CGOSD_BIT_OSD_FLAG));
            end
            if (int_mode && stop_act) begin
                osd_ctrl_q[`CGOSD_BIT_OSD_FLAG]  <= 1'b1;
                osd_ctrl_q[`CGOSD_BIT_OSC_STATE] <= 1'b1;
                if (!on_pll && !on_sub)
                    osd_ctrl_q[`CGOSD_BIT_RING_SEL] <= 1'b1;
            end
            if (int_mode && restart_act) begin
                osd_ctrl_q[`CGOSD_BIT_OSD_FLAG]  <= 1'b1;
                osd_ctrl_q[`CGOSD_BIT_OSC_STATE] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Detection outputs
    // ----------------------------------------
    // Reset request is sticky: only hardware reset releases it
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            osd_irq        <= 1'b0;
            osd_rst_req    <= 1'b0;
            ring_osc_on    <= 1'b0;
            cpu_on_ring    <= 1'b0;
            periph_on_ring <= 1'b0;
        end else begin
            osd_irq <= irq_fire;
            if (stop_act && !int_mode)
                osd_rst_req <= 1'b1;
            if (int_mode && stop_act)
                ring_osc_on <= 1'b1;
            else if (wr && clk_unlk && wr_hit(reg_addr, `CGOSD_OFS_RING_CTRL))
                ring_osc_on <= reg_wdata[0];
            // CPU stays on sub clock in low-speed mode; peripherals still move
            cpu_on_ring    <= osd_ctrl_q[`CGOSD_BIT_RING_SEL] & ~on_sub;
            periph_on_ring <= osd_ctrl_q[`CGOSD_BIT_RING_SEL] | (ring_osc_on & osd_ctrl_q[`CGOSD_BIT_OSC_STATE]);
        end
    end

    // ----------------------------------------
    // Read mux, data one cycle after strobe
    // ----------------------------------------
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CGOSD_OFS_CLK_CTRL0:  reg_rdata <= clk_ctrl0_q;
                `CGOSD_OFS_CLK_CTRL1:  reg_rdata <= clk_ctrl1_q;
                `CGOSD_OFS_OSD_CTRL:   reg_rdata <= osd_ctrl_q;
                `CGOSD_OFS_PLL_CTRL:   reg_rdata <= pll_ctrl_q;
                `CGOSD_OFS_LP_CTRL:    reg_rdata <= lp_ctrl_q;
                `CGOSD_OFS_RING_CTRL:  reg_rdata <= ring_ctrl_q;
                `CGOSD_OFS_PCLK_SEL:   reg_rdata <= pclk_sel_q;
                `CGOSD_OFS_PMODE0:     reg_rdata <= pmode0_q;
                `CGOSD_OFS_PMODE1:     reg_rdata <= pmode1_q;
                `CGOSD_OFS_PWR_CTRL2:  reg_rdata <= pwr_ctrl2_q;
                `CGOSD_OFS_TB2_SPEC:   reg_rdata <= tb2_q;
                `CGOSD_OFS_INV_CTRL0:  reg_rdata <= inv0_q;
                `CGOSD_OFS_INV_CTRL1:  reg_rdata <= inv1_q;
                `CGOSD_OFS_P9_DIR:     reg_rdata <= p9_dir_q;
                `CGOSD_OFS_PIN_ASSIGN: reg_rdata <= pin_asg_q;
                `CGOSD_OFS_SER4_CTRL:  reg_rdata <= ser4_q;
                `CGOSD_OFS_NF_DIR:     reg_rdata <= nf_dir_q;
                `CGOSD_OFS_VDET_CTRL2: reg_rdata <= vdet2_q;
                `CGOSD_OFS_VDET_INT:   reg_rdata <= vdet_int_q;
                `CGOSD_OFS_WPROT:      reg_rdata <= {4'h0, wprot_q};
                default:               reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // cgosd_top

//--- src/cgosd_regs.vh
`ifndef CGOSD_REGS_VH
`define CGOSD_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CGOSD_ADDR_W          8
`define CGOSD_OFS_CLK_CTRL0   8'h00
`define CGOSD_OFS_CLK_CTRL1   8'h04
`define CGOSD_OFS_OSD_CTRL    8'h08
`define CGOSD_OFS_PLL_CTRL    8'h0c
`define CGOSD_OFS_LP_CTRL     8'h10
`define CGOSD_OFS_RING_CTRL   8'h14
`define CGOSD_OFS_PCLK_SEL    8'h18
`define CGOSD_OFS_PMODE0      8'h1c
`define CGOSD_OFS_PMODE1      8'h20
`define CGOSD_OFS_PWR_CTRL2   8'h24
`define CGOSD_OFS_TB2_SPEC    8'h28
`define CGOSD_OFS_INV_CTRL0   8'h2c
`define CGOSD_OFS_INV_CTRL1   8'h30
`define CGOSD_OFS_P9_DIR      8'h34
`define CGOSD_OFS_PIN_ASSIGN  8'h38
`define CGOSD_OFS_SER4_CTRL   8'h3c
`define CGOSD_OFS_NF_DIR      8'h40
`define CGOSD_OFS_VDET_CTRL2  8'h44
`define CGOSD_OFS_VDET_INT    8'h48
`define CGOSD_OFS_WPROT       8'h4c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CGOSD_BIT_PCLK_WAIT_OFF 2
`define CGOSD_BIT_MAIN_OSC_STOP 5
`define CGOSD_BIT_SYSCLK_SUB    7
`define CGOSD_BIT_STOP_REQ      0
`define CGOSD_BIT_PLL_SEL       1
`define CGOSD_BIT_OSD_EN        0
`define CGOSD_BIT_RING_SEL      1
`define CGOSD_BIT_OSD_FLAG      2
`define CGOSD_BIT_OSC_STATE     3
`define CGOSD_BIT_OSD_ACT       7
`define CGOSD_BIT_CLK_LOCK      1
`define CGOSD_BIT_CLK_UNLK      0
`define CGOSD_BIT_PWR_UNLK      1
`define CGOSD_BIT_PORT_UNLK     2
`define CGOSD_BIT_VDET_UNLK     3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CGOSD_RST_CLK_CTRL0   8'h08
`define CGOSD_RST_CLK_CTRL1   8'h20
`define CGOSD_RST_OSD_CTRL    8'h00
`define CGOSD_RST_PLL_CTRL    8'h00
`define CGOSD_RST_GENERIC     8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CGOSD_CLK_MHZ         50
`define CGOSD_OSC_TIMEOUT_NS  2000
`define CGOSD_OSC_TIMEOUT_CYC ((`CGOSD_OSC_TIMEOUT_NS * `CGOSD_CLK_MHZ) / 1000)

`endif

//--- src/cgosd_stop_det.v
`timescale 1ns/1ns
`include "cgosd_regs.vh"

// ----------------------------------------
// Main oscillator watcher: sync, edge detect, quiet-cycle count, stop/restart events
// ----------------------------------------
module cgosd_stop_det #(
    parameter TIMEOUT = `CGOSD_OSC_TIMEOUT_CYC
) (
    input  wire clk_sys,       // System clock
    input  wire sys_rst,       // Async reset, active high
    input  wire osc_in,        // Main oscillator, asynchronous
    output reg  osc_running,   // Level: toggles seen recently
    output reg  stop_evt,      // Pulse: oscillation lost
    output reg  restart_evt    // Pulse: oscillation back
);
    reg        s1_q;
    reg        s2_q;
    reg        s3_q;
    reg [15:0] cnt_q;

    // Two-flop sync; only s2/s3 feed the edge detector
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= osc_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A 250 kHz clock toggles within one timeout; slower clocks look stopped
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q       <= 16'h0000;
            osc_running <= 1'b1;
            stop_evt    <= 1'b0;
            restart_evt <= 1'b0;
        end else begin
            stop_evt    <= 1'b0;
            restart_evt <= 1'b0;
            if (s2_q != s3_q) begin
                cnt_q <= 16'h0000;
                if (!osc_running) begin
                    osc_running <= 1'b1;
                    restart_evt <= 1'b1;
                end
            end else if (cnt_q >= TIMEOUT[15:0]) begin
                if (osc_running) begin
                    osc_running <= 1'b0;
                    stop_evt    <= 1'b1;
                end
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule // cgosd_stop_det

//--- sim/cgosd_top_asserts.sv
`timescale 1ns/1ns
`include "cgosd_regs.vh"
// ----------------------------------------
// Port checks for the clock guard
// ----------------------------------------
module cgosd_top_asserts #(
    parameter OSC_TIMEOUT = `CGOSD_OSC_TIMEOUT_CYC
) (
    input wire logic       clk_sys,        // System clock
    input wire logic       sys_rst,        // Async reset
    input wire logic [7:0] reg_addr,       // Address
    input wire logic [7:0] reg_wdata,      // Write data
    input wire logic       reg_wr,         // Write strobe
    input wire logic       reg_rd,         // Read strobe
    input wire logic [7:0] reg_rdata,      // Read data
    input wire logic       main_osc_in,    // Oscillator pin
    input wire logic       osd_irq,        // Detection interrupt
    input wire logic       osd_rst_req,    // Stop reset
    input wire logic       ring_osc_on,    // Ring osc request
    input wire logic       cpu_on_ring,    // CPU on ring osc
    input wire logic       periph_on_ring  // Peripherals on ring osc
);
    logic [7:0] quiet_q;     // Cycles since the pin last moved
    logic       osc_q;       // Pin level one cycle ago
    logic       irq_seen_q;  // An interrupt was raised
    logic       clr_seen_q;  // Flag cleared since the last interrupt

    // Saturating count, so a long stop cannot wrap and look like activity
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_q <= 8'h00;
            osc_q <= 1'b0;
            irq_seen_q <= 1'b0;
            clr_seen_q <= 1'b0;
        end else begin
            osc_q <= main_osc_in;
            if (osc_q != main_osc_in) quiet_q <= 8'h00;
            else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
            if (osd_irq) irq_seen_q <= 1'b1;
            if (osd_irq) clr_seen_q <= 1'b0;
            else if (reg_wr && reg_addr == `CGOSD_OFS_OSD_CTRL && !reg_wdata[`CGOSD_BIT_OSD_FLAG]) clr_seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_irq_pulse: assert property (osd_irq |=> !osd_irq)
        else $error("interrupt pulse longer than one cycle");
    a_flag_gate: assert property (osd_irq && irq_seen_q |-> clr_seen_q)
        else $error("interrupt repeated while flag set");
    a_rst_hold: assert property (osd_rst_req |=> osd_rst_req)
        else $error("stop reset released without reset");
    a_rst_no_irq: assert property (osd_rst_req |-> !osd_irq)
        else $error("interrupt during stop reset");
    a_rst_cause: assert property ($rose(osd_rst_req) |-> quiet_q >= OSC_TIMEOUT)
        else $error("stop reset without a stopped oscillator");
    a_irq_cause: assert property (osd_irq |-> (quiet_q >= OSC_TIMEOUT || quiet_q <= 8'h08))
        else $error("interrupt without stop or restart");
    a_cpu_periph: assert property (cpu_on_ring |-> periph_on_ring)
        else $error("cpu on ring osc but peripherals not");
    a_reset_quiet: assert property ($past(sys_rst) |-> !osd_irq && !osd_rst_req && !ring_osc_on)
        else $error("outputs active right after reset");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule // cgosd_top_asserts

//--- sim/cgosd_osc_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Main oscillator model
// ----------------------------------------
module cgosd_osc_model #(
    parameter HALF_NS = 30
) (
    input  wire logic run,  // Oscillator enabled
    output logic      osc   // Oscillator output
);
    // About 16.7 MHz, well above the detection floor; a halted crystal holds its level
    initial begin
        osc = 1'b0;
        // Offset keeps pin edges off the system clock edges
        #5;
        forever begin
            #(HALF_NS);
            if (run) osc = ~osc;
        end
    end
endmodule // cgosd_osc_model

//--- sim/cgosd_top_tb.sv
`timescale 1ns/1ns
`include "cgosd_regs.vh"
module cgosd_top_tb;
    localparam TMO = 10;
    logic       clk_sys, sys_rst, reg_wr, reg_rd, osc_run, main_osc_in;
    logic       osd_irq, osd_rst_req, ring_osc_on, cpu_on_ring, periph_on_ring;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int         num_errors, cmp_count;

    cgosd_top #(.OSC_TIMEOUT(TMO)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_osc_in(main_osc_in), .osd_irq(osd_irq), .osd_rst_req(osd_rst_req), .ring_osc_on(ring_osc_on),
        .cpu_on_ring(cpu_on_ring), .periph_on_ring(periph_on_ring));
    cgosd_osc_model u_osc (.run(osc_run), .osc(main_osc_in));

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check(reg_rdata, exp);
    endtask
    // Move the oscillator, then look for the one-cycle interrupt under a bound
    task osc_step(input logic run, input logic exp);
        logic seen;
        seen = 1'b0;
        osc_run = run;
        for (int i = 0; i < TMO + 20 && !seen; i++) begin
            @(negedge clk_sys);
            if (osd_irq === 1'b1) seen = 1'b1;
        end
        check({7'h00, seen}, {7'h00, exp});
    endtask
    task do_reset;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask
    task complete_run;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // A hung wait loop cannot outlast this
    initial begin
        #400000;
        num_errors++;
        complete_run;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        osc_run = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        do_reset;
        rdc(`CGOSD_OFS_CLK_CTRL0, `CGOSD_RST_CLK_CTRL0);
        rdc(`CGOSD_OFS_CLK_CTRL1, `CGOSD_RST_CLK_CTRL1);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h00);
        wr(8'hfc, 8'hff);
        rdc(8'hfc, 8'h00);
        // Protected groups, each behind its own unlock bit
        wr(`CGOSD_OFS_OSD_CTRL, 8'h81);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h00);
        wr(`CGOSD_OFS_WPROT, 8'h01);
        wr(`CGOSD_OFS_CLK_CTRL1, 8'h22);
        rdc(`CGOSD_OFS_CLK_CTRL1, 8'h22);
        wr(`CGOSD_OFS_CLK_CTRL1, 8'h20);
        wr(`CGOSD_OFS_PMODE0, 8'h01);
        rdc(`CGOSD_OFS_PMODE0, 8'h00);
        wr(`CGOSD_OFS_WPROT, 8'h03);
        wr(`CGOSD_OFS_PMODE0, 8'h01);
        rdc(`CGOSD_OFS_PMODE0, 8'h01);
        wr(`CGOSD_OFS_P9_DIR, 8'h01);
        rdc(`CGOSD_OFS_P9_DIR, 8'h00);
        wr(`CGOSD_OFS_WPROT, 8'h07);
        wr(`CGOSD_OFS_P9_DIR, 8'h01);
        rdc(`CGOSD_OFS_P9_DIR, 8'h01);
        rdc(`CGOSD_OFS_WPROT, 8'h03);
        wr(`CGOSD_OFS_P9_DIR, 8'h00);
        rdc(`CGOSD_OFS_P9_DIR, 8'h01);
        wr(`CGOSD_OFS_VDET_CTRL2, 8'h01);
        rdc(`CGOSD_OFS_VDET_CTRL2, 8'h00);
        wr(`CGOSD_OFS_WPROT, 8'h0b);
        wr(`CGOSD_OFS_VDET_CTRL2, 8'h01);
        rdc(`CGOSD_OFS_VDET_CTRL2, 8'h01);
        rdc(`CGOSD_OFS_WPROT, 8'h0b);
        // Clock lock: engage, then try every locked bit
        wr(`CGOSD_OFS_PWR_CTRL2, 8'h02);
        wr(`CGOSD_OFS_WPROT, 8'h01);
        wr(`CGOSD_OFS_CLK_CTRL0, 8'hac);
        rdc(`CGOSD_OFS_CLK_CTRL0, 8'h08);
        wr(`CGOSD_OFS_CLK_CTRL1, 8'h23);
        rdc(`CGOSD_OFS_CLK_CTRL1, 8'h20);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h01);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h00);
        wr(`CGOSD_OFS_PLL_CTRL, 8'hff);
        rdc(`CGOSD_OFS_PLL_CTRL, 8'h00);
        wr(`CGOSD_OFS_WPROT, 8'h03);
        wr(`CGOSD_OFS_PWR_CTRL2, 8'h00);
        wr(`CGOSD_OFS_WPROT, 8'h01);
        // Main-source stop and restart, flag gating the second interrupt
        wr(`CGOSD_OFS_OSD_CTRL, 8'h81);
        osc_step(1'b0, 1'b1);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h8f);
        check({5'h00, ring_osc_on, cpu_on_ring, periph_on_ring}, 8'h07);
        osc_step(1'b1, 1'b0);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h87);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h83);
        osc_step(1'b0, 1'b1);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h83);
        osc_step(1'b1, 1'b1);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h87);
        // PLL-source stop: ring select left to software
        do_reset;
        wr(`CGOSD_OFS_WPROT, 8'h01);
        wr(`CGOSD_OFS_PLL_CTRL, 8'h80);
        wr(`CGOSD_OFS_CLK_CTRL1, 8'h22);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h81);
        osc_step(1'b0, 1'b1);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h8d);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h83);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h8b);
        osc_step(1'b1, 1'b1);
        rdc(`CGOSD_OFS_OSD_CTRL, 8'h87);
        // Low-speed stop: CPU stays on the sub clock
        do_reset;
        wr(`CGOSD_OFS_WPROT, 8'h01);
        wr(`CGOSD_OFS_CLK_CTRL0, 8'h88);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h81);
        osc_step(1'b0, 1'b1);
        // Peripheral select follows the status bits one cycle after the interrupt
        @(negedge clk_sys);
        check({5'h00, ring_osc_on, cpu_on_ring, periph_on_ring}, 8'h05);
        osc_step(1'b1, 1'b0);
        // Detection off, then reset action armed while running
        do_reset;
        osc_step(1'b0, 1'b0);
        check({7'h00, osd_rst_req}, 8'h00);
        osc_step(1'b1, 1'b0);
        wr(`CGOSD_OFS_WPROT, 8'h01);
        wr(`CGOSD_OFS_OSD_CTRL, 8'h01);
        osc_step(1'b0, 1'b0);
        check({7'h00, osd_rst_req}, 8'h01);
        osc_step(1'b1, 1'b0);
        check({7'h00, osd_rst_req}, 8'h01);
        do_reset;
        @(negedge clk_sys);
        check({7'h00, osd_rst_req}, 8'h00);
        complete_run;
    end
endmodule // cgosd_top_tb

bind cgosd_top cgosd_top_asserts #(.OSC_TIMEOUT(OSC_TIMEOUT)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .main_osc_in(main_osc_in), .osd_irq(osd_irq), .osd_rst_req(osd_rst_req), .ring_osc_on(ring_osc_on),
    .cpu_on_ring(cpu_on_ring), .periph_on_ring(periph_on_ring));
